// ### ifu_pkg.sv
package ifu_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  OFF_EDGE     = 8'h00;
   localparam logic [7:0]  OFF_CTRL_A   = 8'h04;
   localparam logic [7:0]  OFF_CTRL_B   = 8'h08;
   localparam logic [7:0]  OFF_GROUP    = 8'h0c;
   localparam logic [7:0]  OFF_EVT_STAT = 8'h10;
   localparam logic [7:0]  OFF_EVT_MASK = 8'h14;

   // ****************************************
   // Implemented bits and reset values
   // ****************************************
   localparam logic [7:0]  MASK_EDGE    = 8'h03;
   localparam logic [7:0]  MASK_CTRL_A  = 8'h7f;
   localparam logic [7:0]  MASK_CTRL_B  = 8'hff;
   localparam logic [7:0]  MASK_GROUP   = 8'h33;
   localparam logic [7:0]  RST_REG      = 8'h00;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CA_GRP_F = 6;
   localparam int CA_ADC_F = 5;
   localparam int CA_PIN_F = 4;
   localparam int CA_GRP_E = 3;
   localparam int CA_ADC_E = 2;
   localparam int CA_PIN_E = 1;
   localparam int CA_GLB_E = 0;
   localparam int CB_TK1_F = 7;
   localparam int CB_TK0_F = 6;
   localparam int CB_SER_F = 5;
   localparam int CB_EEP_F = 4;
   localparam int CB_TK1_E = 3;
   localparam int CB_TK0_E = 2;
   localparam int CB_SER_E = 1;
   localparam int CB_EEP_E = 0;
   localparam int GM_MA_F  = 5;
   localparam int GM_MP_F  = 4;
   localparam int GM_MA_E  = 1;
   localparam int GM_MP_E  = 0;

   // Edge select codes
   localparam logic [1:0] EDGE_OFF  = 2'b00;
   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_FALL = 2'b10;
   localparam logic [1:0] EDGE_BOTH = 2'b11;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Serviced source, in priority order
   typedef enum logic [2:0] {
      SRC_PIN, SRC_GROUP, SRC_ADC, SRC_SERIAL, SRC_EEPROM, SRC_TICK0, SRC_TICK1
   } ifu_src_t;

   function automatic logic ifu_addr_ok(input logic [ADDR_W-1:0] a);
      ifu_addr_ok = (a == OFF_EDGE) || (a == OFF_CTRL_A) || (a == OFF_CTRL_B) ||
                    (a == OFF_GROUP) || (a == OFF_EVT_STAT) || (a == OFF_EVT_MASK);
   endfunction : ifu_addr_ok

endpackage : ifu_pkg

// ### ifu_reg_if.sv
`timescale 1ns/1ps
interface ifu_reg_if;
   logic       wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic       rd_en;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   modport slv  (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
   modport core (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : ifu_reg_if

// ### ifu_edge_det.sv
`timescale 1ns/1ps
module ifu_edge_det
   import ifu_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Pin and selection
   input  wire logic       i_pin,
   input  wire logic [1:0] i_sel,
   output logic            o_edge
);
   logic prev_ff;
   logic armed_ff;

   // Armed one cycle after reset so a high pin is not seen as a rise
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_ff  <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         prev_ff  <= i_pin;
         armed_ff <= 1'b1;
      end
   end

   always_comb begin
      case (i_sel)
         EDGE_RISE: o_edge = armed_ff & i_pin & ~prev_ff;
         EDGE_FALL: o_edge = armed_ff & ~i_pin & prev_ff;
         EDGE_BOTH: o_edge = armed_ff & (i_pin ^ prev_ff);
         default:   o_edge = 1'b0;
      endcase
   end

   a_edge_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_sel == EDGE_OFF) |-> !o_edge)
      else $error("edge seen while pin detection disabled");
   a_edge_rise: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_sel == EDGE_RISE) && armed_ff && $rose(i_pin) |-> o_edge)
      else $error("rising edge missed");

endmodule : ifu_edge_det

// ### ifu_axil_slave.sv
`timescale 1ns/1ps
module ifu_axil_slave
   import ifu_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // Write channels
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   output logic [1:0]             o_bresp,
   // Read channels
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   input  wire logic [ADDR_W-1:0] i_araddr,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   // Register side
   ifu_reg_if.slv                 reg_io
);
   logic              aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff;
   logic              arready_ff, rvalid_ff, wstrb0_ff;
   logic [ADDR_W-1:0] aw_addr_ff;
   logic [7:0]        w_data_ff;
   logic [1:0]        bresp_ff, rresp_ff;
   logic [31:0]       rdata_ff;
   logic              wr_go, ar_take;
   logic              nxt_aw_full, nxt_w_full, nxt_bvalid, nxt_rvalid;

   always_comb begin
      wr_go       = aw_full_ff & w_full_ff & ~bvalid_ff;
      ar_take     = i_arvalid & arready_ff;
      nxt_aw_full = (aw_full_ff | (i_awvalid & awready_ff)) & ~wr_go;
      nxt_w_full  = (w_full_ff | (i_wvalid & wready_ff)) & ~wr_go;
      nxt_bvalid  = bvalid_ff ? ~i_bready : wr_go;
      nxt_rvalid  = rvalid_ff ? ~i_rready : ar_take;
   end

   // Unmapped or low-lane-less writes are answered but change nothing
   assign reg_io.wr_en   = wr_go & wstrb0_ff & ifu_addr_ok(aw_addr_ff);
   assign reg_io.wr_addr = aw_addr_ff;
   assign reg_io.wr_data = w_data_ff;
   assign reg_io.rd_en   = ar_take & ifu_addr_ok(i_araddr);
   assign reg_io.rd_addr = i_araddr;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_full_ff <= 1'b0;
         w_full_ff  <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         aw_addr_ff <= '0;
         w_data_ff  <= 8'h00;
         wstrb0_ff  <= 1'b0;
      end else begin
         aw_full_ff <= nxt_aw_full;
         w_full_ff  <= nxt_w_full;
         awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
         wready_ff  <= ~nxt_w_full & ~nxt_bvalid;
         bvalid_ff  <= nxt_bvalid;
         if (i_awvalid & awready_ff) begin
            aw_addr_ff <= i_awaddr;
         end
         if (i_wvalid & wready_ff) begin
            w_data_ff <= i_wdata[7:0];
            wstrb0_ff <= i_wstrb[0];
         end
         if (wr_go) begin
            bresp_ff <= ifu_addr_ok(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= RESP_OKAY;
      end else begin
         arready_ff <= ~nxt_rvalid;
         rvalid_ff  <= nxt_rvalid;
         if (ar_take) begin
            rdata_ff <= ifu_addr_ok(i_araddr) ? {24'h00_0000, reg_io.rd_data} : 32'h0000_0000;
            rresp_ff <= ifu_addr_ok(i_araddr) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign o_awready = awready_ff;
   assign o_wready  = wready_ff;
   assign o_bvalid  = bvalid_ff;
   assign o_bresp   = bresp_ff;
   assign o_arready = arready_ff;
   assign o_rvalid  = rvalid_ff;
   assign o_rdata   = rdata_ff;
   assign o_rresp   = rresp_ff;

endmodule : ifu_axil_slave

// ### ifu_top.sv
// Contract
// - Edge field: off, rise, fall, both
// - Unimplemented register bits read zero
// - Every source has flag and enable
// - First control register layout, reset zero
// - Second control register layout, reset zero
// - Group register holds match flags, enables
// - Timer matches feed shared group request
// - Exactly one external pin source
// - Flags set regardless; global enable gates o_irq_req, not o_irq
// - Servicing clears global enable, flags still record
// - Full stack withholds acknowledgement
// - Pin service clears pin flag
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module ifu_top
   import ifu_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   // Register bus, write
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   output logic                   o_bvalid,
   input  wire logic              i_bready,
   output logic [1:0]             o_bresp,
   // Register bus, read
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   input  wire logic [ADDR_W-1:0] i_araddr,
   output logic                   o_rvalid,
   input  wire logic              i_rready,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   // Interrupt sources
   input  wire logic              i_ext_pin,
   input  wire logic              i_adc_done,
   input  wire logic              i_tick0,
   input  wire logic              i_tick1,
   input  wire logic              i_serial_req,
   input  wire logic              i_eeprom_done,
   input  wire logic              i_match_p,
   input  wire logic              i_match_a,
   // Processor core
   input  wire logic              i_stack_full,
   input  wire logic              i_irq_ack,
   output logic                   o_irq_req,
   output ifu_src_t               o_irq_vec,
   output logic                   o_irq
);

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_meta_ff;
   logic rst_n;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_n       <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n       <= rst_meta_ff;
      end
   end

   // ****************************************
   // Bus slave and pin edge detection
   // ****************************************
   ifu_reg_if reg_io ();
   logic      pin_edge;

   ifu_axil_slave u_slave (
      .i_clk     (i_clk),
      .i_rst_n   (rst_n),
      .i_awvalid (i_awvalid),
      .o_awready (o_awready),
      .i_awaddr  (i_awaddr),
      .i_wvalid  (i_wvalid),
      .o_wready  (o_wready),
      .i_wdata   (i_wdata),
      .i_wstrb   (i_wstrb),
      .o_bvalid  (o_bvalid),
      .i_bready  (i_bready),
      .o_bresp   (o_bresp),
      .i_arvalid (i_arvalid),
      .o_arready (o_arready),
      .i_araddr  (i_araddr),
      .o_rvalid  (o_rvalid),
      .i_rready  (i_rready),
      .o_rdata   (o_rdata),
      .o_rresp   (o_rresp),
      .reg_io    (reg_io.slv)
   );

   logic [7:0] edge_ff, ca_ff, cb_ff, gm_ff;

   // Single external source; every other request is internal
   ifu_edge_det u_edge (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .i_pin   (i_ext_pin),
      .i_sel   (edge_ff[1:0]),
      .o_edge  (pin_edge)
   );

   // ****************************************
   // Service selection
   // ****************************************
   logic [6:0] pend;
   logic       ack_take;
   ifu_src_t   pick;
   logic [7:0] ca_set, cb_set, gm_set, ca_clr, cb_clr;
   logic       grp_req;

   // An ack outside a standing request is ignored
   assign ack_take = i_irq_ack & o_irq_req;

   // Sub-flags stay until software clears them, so the group keeps asking
   assign grp_req = (gm_ff[GM_MA_F] & gm_ff[GM_MA_E]) |
                    (gm_ff[GM_MP_F] & gm_ff[GM_MP_E]);

   always_comb begin
      pend = {cb_ff[CB_TK1_F] & cb_ff[CB_TK1_E],
              cb_ff[CB_TK0_F] & cb_ff[CB_TK0_E],
              cb_ff[CB_EEP_F] & cb_ff[CB_EEP_E],
              cb_ff[CB_SER_F] & cb_ff[CB_SER_E],
              ca_ff[CA_ADC_F] & ca_ff[CA_ADC_E],
              ca_ff[CA_GRP_F] & ca_ff[CA_GRP_E],
              ca_ff[CA_PIN_F] & ca_ff[CA_PIN_E]};
      // Walk down so the lowest pending index is written last and wins
      pick = SRC_TICK1;
      for (int i = 6; i >= 0; i--) begin
         if (pend[i]) begin
            pick = ifu_src_t'(i[2:0]);
         end
      end
   end

   // Hardware sets and service clears
   always_comb begin
      ca_set = 8'h00;
      cb_set = 8'h00;
      gm_set = 8'h00;
      ca_clr = 8'h00;
      cb_clr = 8'h00;
      ca_set[CA_PIN_F] = pin_edge;
      ca_set[CA_ADC_F] = i_adc_done;
      ca_set[CA_GRP_F] = grp_req;
      cb_set[CB_TK1_F] = i_tick1;
      cb_set[CB_TK0_F] = i_tick0;
      cb_set[CB_SER_F] = i_serial_req;
      cb_set[CB_EEP_F] = i_eeprom_done;
      gm_set[GM_MA_F]  = i_match_a;
      gm_set[GM_MP_F]  = i_match_p;
      if (ack_take) begin
         ca_clr[CA_GLB_E] = 1'b1;
         case (o_irq_vec)
            SRC_PIN:    ca_clr[CA_PIN_F] = 1'b1;
            SRC_GROUP:  ca_clr[CA_GRP_F] = 1'b1;
            SRC_ADC:    ca_clr[CA_ADC_F] = 1'b1;
            SRC_SERIAL: cb_clr[CB_SER_F] = 1'b1;
            SRC_EEPROM: cb_clr[CB_EEP_F] = 1'b1;
            SRC_TICK0:  cb_clr[CB_TK0_F] = 1'b1;
            SRC_TICK1:  cb_clr[CB_TK1_F] = 1'b1;
            default:    ca_clr[CA_GLB_E] = 1'b1;
         endcase
      end
   end

   // ****************************************
   // Interrupt control registers
   // ****************************************
   logic wr_edge, wr_ca, wr_cb, wr_gm;

   assign wr_edge = reg_io.wr_en & (reg_io.wr_addr == OFF_EDGE);
   assign wr_ca   = reg_io.wr_en & (reg_io.wr_addr == OFF_CTRL_A);
   assign wr_cb   = reg_io.wr_en & (reg_io.wr_addr == OFF_CTRL_B);
   assign wr_gm   = reg_io.wr_en & (reg_io.wr_addr == OFF_GROUP);

   // A hardware set wins over a same-cycle clear or software write of zero
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         edge_ff <= RST_REG;
         ca_ff   <= RST_REG;
         cb_ff   <= RST_REG;
         gm_ff   <= RST_REG;
      end else begin
         edge_ff <= (wr_edge ? reg_io.wr_data : edge_ff) & MASK_EDGE;
         ca_ff   <= (((wr_ca ? reg_io.wr_data : ca_ff) & ~ca_clr) | ca_set) & MASK_CTRL_A;
         cb_ff   <= (((wr_cb ? reg_io.wr_data : cb_ff) & ~cb_clr) | cb_set) & MASK_CTRL_B;
         gm_ff   <= ((wr_gm ? reg_io.wr_data : gm_ff) | gm_set) & MASK_GROUP;
      end
   end

   // ****************************************
   // Request to the core
   // ****************************************
   logic     req_ff;
   ifu_src_t vec_ff;

   // Request drops the cycle after the ack so one service is never taken twice
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_ff <= 1'b0;
         vec_ff <= SRC_PIN;
      end else begin
         req_ff <= ca_ff[CA_GLB_E] & (|pend) & ~i_stack_full & ~ack_take;
         // Vector frozen while the request stands, so the core clears what it saw
         if (!req_ff || ack_take) begin
            vec_ff <= pick;
         end
      end
   end

   assign o_irq_req = req_ff;
   assign o_irq_vec = vec_ff;

   // ****************************************
   // Event status, mask and interrupt line
   // ****************************************
   logic [7:0] stat_ff, mask_ff, evt, nxt_stat;
   logic       irq_ff;

   assign evt = {i_match_a, i_match_p, i_eeprom_done, i_serial_req,
                 i_tick1, i_tick0, i_adc_done, pin_edge};

   // Read of status clears it; events of the same cycle survive
   always_comb begin
      nxt_stat = stat_ff;
      if (reg_io.rd_en && (reg_io.rd_addr == OFF_EVT_STAT)) begin
         nxt_stat = 8'h00;
      end
      nxt_stat = nxt_stat | evt;
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_ff <= RST_REG;
         mask_ff <= RST_REG;
         irq_ff  <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         if (reg_io.wr_en && (reg_io.wr_addr == OFF_EVT_MASK)) begin
            mask_ff <= reg_io.wr_data;
         end
         irq_ff <= |(nxt_stat & mask_ff);
      end
   end

   assign o_irq = irq_ff;

   // ****************************************
   // Read data
   // ****************************************
   always_comb begin
      case (reg_io.rd_addr)
         OFF_EDGE:     reg_io.rd_data = edge_ff & MASK_EDGE;
         OFF_CTRL_A:   reg_io.rd_data = ca_ff & MASK_CTRL_A;
         OFF_CTRL_B:   reg_io.rd_data = cb_ff;
         OFF_GROUP:    reg_io.rd_data = gm_ff & MASK_GROUP;
         OFF_EVT_STAT: reg_io.rd_data = stat_ff;
         OFF_EVT_MASK: reg_io.rd_data = mask_ff;
         default:      reg_io.rd_data = 8'h00;
      endcase
   end

   // ****************************************
   // Checks
   // ****************************************
   a_pin_flag_set: assert property (@(posedge i_clk) disable iff (!rst_n)
      pin_edge |=> ca_ff[CA_PIN_F])
      else $error("pin edge did not set pin flag");

   a_reserved_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
      ((edge_ff & ~MASK_EDGE) == 8'h00) && !ca_ff[7] && ((gm_ff & ~MASK_GROUP) == 8'h00))
      else $error("unimplemented bit holds one");

   a_flag_no_enable: assert property (@(posedge i_clk) disable iff (!rst_n)
      i_adc_done && !ca_ff[CA_ADC_E] |=> ca_ff[CA_ADC_F])
      else $error("converter flag lost while disabled");

   a_global_gate: assert property (@(posedge i_clk) disable iff (!rst_n)
      !ca_ff[CA_GLB_E] |=> !req_ff)
      else $error("request raised with global enable clear");

   a_ack_clears_glb: assert property (@(posedge i_clk) disable iff (!rst_n)
      ack_take |=> !ca_ff[CA_GLB_E] ##1 !req_ff)
      else $error("service did not clear global enable");

   a_stack_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
      i_stack_full |=> !req_ff)
      else $error("request raised with full stack");

   a_pin_service: assert property (@(posedge i_clk) disable iff (!rst_n)
      ack_take && (vec_ff == SRC_PIN) && !pin_edge |=> !ca_ff[CA_PIN_F])
      else $error("pin service left pin flag set");

   a_group_feed: assert property (@(posedge i_clk) disable iff (!rst_n)
      gm_ff[GM_MA_F] && gm_ff[GM_MA_E] |=> ca_ff[CA_GRP_F])
      else $error("enabled match flag did not set group flag");

   a_match_sticky: assert property (@(posedge i_clk) disable iff (!rst_n)
      i_match_p ##1 !wr_gm [*2] |-> gm_ff[GM_MP_F])
      else $error("match P flag not held");

   a_irq_line: assert property (@(posedge i_clk) disable iff (!rst_n)
      $rose(irq_ff) |-> $past(|evt) || ($past(mask_ff) != $past(mask_ff, 2)))
      else $error("interrupt line rose with no event");

   // Set-wins checks: a flag raised by its source is never lost to a clear
   a_flags_a_set: assert property (@(posedge i_clk) disable iff (!rst_n)
      |ca_set |=> ((ca_ff & $past(ca_set)) == $past(ca_set)))
      else $error("control A flag not set");

   a_flags_b_set: assert property (@(posedge i_clk) disable iff (!rst_n)
      |cb_set |=> ((cb_ff & $past(cb_set)) == $past(cb_set)))
      else $error("control B flag not set");

   a_match_set: assert property (@(posedge i_clk) disable iff (!rst_n)
      |gm_set |=> ((gm_ff & $past(gm_set)) == $past(gm_set)))
      else $error("match flag not set");

   a_idle_no_req: assert property (@(posedge i_clk) disable iff (!rst_n)
      !(|pend) |=> !req_ff)
      else $error("request raised with nothing pending");

   a_full_release: assert property (@(posedge i_clk) disable iff (!rst_n)
      ca_ff[CA_GLB_E] && (|pend) && !i_stack_full && !ack_take |=> req_ff)
      else $error("request withheld with room on stack");

   a_ack_drops_req: assert property (@(posedge i_clk) disable iff (!rst_n)
      ack_take |=> !req_ff)
      else $error("request held after service");

endmodule : ifu_top

// ### ifu_core_model.sv
`timescale 1ns/1ps
module ifu_core_model
   import ifu_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Request from controller
   input  wire logic       i_irq_req,
   input  wire ifu_src_t   i_irq_vec,
   // Test controls
   input  wire logic       i_full,
   input  wire logic [1:0] i_lag,
   // Answer to controller
   output logic            o_stack_full,
   output logic            o_irq_ack,
   output ifu_src_t        o_vec,
   output logic [7:0]      o_taken
);
   logic [1:0] wait_ff;
   logic       done_ff;

   // Stack state comes straight from the bench
   assign o_stack_full = i_full;

   // Ack once per request, after a chosen lag; never twice for one
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_ff   <= 2'h0;
         done_ff   <= 1'b0;
         o_irq_ack <= 1'b0;
         o_vec     <= SRC_PIN;
         o_taken   <= 8'h00;
      end else begin
         o_irq_ack <= 1'b0;
         if (!i_irq_req) begin
            wait_ff <= 2'h0;
            done_ff <= 1'b0;
         end else if (!done_ff && wait_ff == i_lag) begin
            o_irq_ack <= 1'b1;
            done_ff   <= 1'b1;
            o_vec     <= i_irq_vec;
            o_taken   <= o_taken + 8'h01;
         end else if (!done_ff) begin
            wait_ff <= wait_ff + 2'h1;
         end
      end
   end
endmodule : ifu_core_model

// ### interrupt_flag_enable_unit_tb_top.sv
`timescale 1ns/1ps
module interrupt_flag_enable_unit_tb_top
   import ifu_pkg::*;
();
   logic        clk, rst_n, awv, wv, bready, arv, rready, pin, full, irq_req, irq, full_c;
   logic        awr, wrdy, bv, arr, rv, ack;
   logic [7:0]  awaddr, araddr, a, t;
   logic [31:0] wdata, rdata, rd_val;
   logic [6:0]  src;
   logic [1:0]  lag, bresp, rresp, resp;
   ifu_src_t    vec, cvec;
   logic [7:0]  taken;
   logic [7:0]  regs [4];
   int          err_total, n_compared, cyc, seed;

   ifu_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awaddr),
      .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(bready),
      .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr), .i_araddr(araddr), .o_rvalid(rv),
      .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_ext_pin(pin), .i_adc_done(src[0]),
      .i_tick0(src[1]), .i_tick1(src[2]), .i_serial_req(src[3]), .i_eeprom_done(src[4]),
      .i_match_p(src[5]), .i_match_a(src[6]), .i_stack_full(full), .i_irq_ack(ack),
      .o_irq_req(irq_req), .o_irq_vec(cvec), .o_irq(irq));
   ifu_core_model u_core (.i_clk(clk), .i_rst_n(rst_n), .i_irq_req(irq_req), .i_irq_vec(cvec),
      .i_full(full_c), .i_lag(lag), .o_stack_full(full), .o_irq_ack(ack), .o_vec(vec), .o_taken(taken));

   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   // Leading edge keeps a strobe from being set twice in one step
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      awaddr <= ad;
      wdata  <= {24'h0, d};
      awv    <= 1'b1;
      wv     <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
      end while (!bv);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] ad);
      @(posedge clk);
      araddr <= ad;
      arv    <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
      rd_val = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
      rd(ad);
      chk($sformatf("reg %h", ad), e, rd_val);
   endtask : rchk

   task automatic pulse(input int i);
      @(posedge clk);
      src[i] <= 1'b1;
      @(posedge clk);
      src <= 7'h00;
      repeat (3) @(posedge clk);
   endtask : pulse

   task automatic serve(input logic [7:0] t0);
      for (int n = 0; n < 60 && taken == t0; n++) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask : serve

   task automatic conclude;
      if (err_total == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude

   function automatic logic [31:0] pin_exp(input logic [1:0] c, input logic rise);
      return (rise ? c[0] : c[1]) ? 32'h10 : 32'h0;
   endfunction : pin_exp

   function automatic logic [31:0] masked(input logic [7:0] ad, input logic [7:0] d);
      return {24'h0, d & (ad == OFF_EDGE ? 8'h03 : ad == OFF_CTRL_B ? 8'hff : 8'h33)};
   endfunction : masked

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         conclude();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {rst_n, awv, wv, bready, arv, rready, pin, full_c} = 8'h00;
      {awaddr, araddr, wdata, src, lag} = '0;
      {err_total, n_compared, cyc} = '0;
      seed = 32'h12d1;
      regs = '{OFF_EDGE, OFF_CTRL_A, OFF_CTRL_B, OFF_GROUP};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int k = 0; k < 4; k++) rchk(regs[k], 32'h0);
      wr(OFF_CTRL_A, 8'hfe);
      rchk(OFF_CTRL_A, 32'h7e);
      chk("req", 32'h0, {31'h0, irq_req});
      for (int k = 0; k < 9; k++) begin
         a = regs[(k % 3 == 0) ? 0 : k % 3 + 1];
         t = 8'($random(seed));
         wr(a, t);
         rchk(a, masked(a, t));
      end
      for (int k = 3; k >= 0; k--) wr(regs[k], 8'h00);
      wr(8'h18, 8'hff);
      chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      rd(8'h18);
      chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      chk("rdata", 32'h0, rd_val);
      for (int c = 0; c < 4; c++) begin
         wr(OFF_EDGE, 8'(c));
         pin <= 1'b1;
         repeat (3) @(posedge clk);
         rchk(OFF_CTRL_A, pin_exp(2'(c), 1'b1));
         wr(OFF_CTRL_A, 8'h00);
         pin <= 1'b0;
         repeat (3) @(posedge clk);
         rchk(OFF_CTRL_A, pin_exp(2'(c), 1'b0));
         wr(OFF_CTRL_A, 8'h00);
      end
      for (int k = 1; k < 5; k++) pulse(k);
      rchk(OFF_CTRL_B, 32'hf0);
      rchk(OFF_EVT_STAT, 32'h3d);
      rchk(OFF_EVT_STAT, 32'h0);
      wr(OFF_EVT_MASK, 8'h02);
      pulse(0);
      chk("irq", 32'h1, {31'h0, irq});
      rchk(OFF_EVT_STAT, 32'h02);
      repeat (2) @(posedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      rchk(OFF_CTRL_A, 32'h20);
      chk("req", 32'h0, {31'h0, irq_req});
      wr(OFF_CTRL_A, 8'h00);
      wr(OFF_GROUP, 8'h01);
      pulse(5);
      pulse(6);
      rchk(OFF_GROUP, 32'h31);
      rchk(OFF_CTRL_A, 32'h40);
      t = taken;
      wr(OFF_CTRL_A, 8'h09);
      serve(t);
      chk("vec", {29'h0, SRC_GROUP}, {29'h0, vec});
      rchk(OFF_CTRL_A, 32'h48);
      wr(OFF_GROUP, 8'h00);
      wr(OFF_CTRL_A, 8'h00);
      lag <= 2'($random(seed));
      full_c <= 1'b1;
      wr(OFF_EDGE, 8'h01);
      wr(OFF_CTRL_A, 8'h03);
      t = taken;
      pin <= 1'b1;
      repeat (6) @(posedge clk);
      chk("req", 32'h0, {31'h0, irq_req});
      rchk(OFF_CTRL_A, 32'h13);
      full_c <= 1'b0;
      serve(t);
      chk("vec", {29'h0, SRC_PIN}, {29'h0, vec});
      rchk(OFF_CTRL_A, 32'h02);
      pin <= 1'b0;
      conclude();
   end
endmodule : interrupt_flag_enable_unit_tb_top
